// file: design/rls_lane_tracker.sv
// Per PCS lane sync, demultiplex and physical lane index tracking
`timescale 1ns/100ps
`include "rls_consts.svh"
module rls_lane_tracker
   import rls_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic [`RLS_NUM_LANES-1:0] block_lock,
   input wire logic [`RLS_NUM_LANES-1:0] marker_found,
   input wire logic [`RLS_NUM_LANES-1:0] marker_bad,
   input wire logic [`RLS_NUM_LANES*`RLS_IDX_W-1:0] marker_phys,
   output logic [`RLS_NUM_LANES-1:0] synced_r,
   output logic [`RLS_NUM_LANES-1:0] demuxed_r,
   output logic [`RLS_NUM_LANES*`RLS_IDX_W-1:0] phys_idx_r
);

   logic [`RLS_NUM_LANES-1:0] synced_nxt;
   logic [`RLS_NUM_LANES-1:0] demuxed_nxt;
   logic [`RLS_NUM_LANES-1:0] idx_load;

   // Sync needs both word lock and a seen marker; losing lock drops it
   assign idx_load = block_lock & marker_found;
   assign synced_nxt = block_lock & (synced_r | marker_found);
   // A malformed marker means the lane can no longer be trusted as demuxed
   assign demuxed_nxt = block_lock & ~marker_bad & (demuxed_r | marker_found);

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         synced_r <= '0;
         demuxed_r <= '0;
         phys_idx_r <= '0;
      end
      else
      begin
         synced_r <= synced_nxt;
         demuxed_r <= demuxed_nxt;
         for (int i = 0; i < `RLS_NUM_LANES; i++)
         begin
            if (idx_load[i])
            begin
               phys_idx_r[i*`RLS_IDX_W +: `RLS_IDX_W] <= marker_phys[i*`RLS_IDX_W +: `RLS_IDX_W];
            end
         end
      end
   end
endmodule

// file: design/rls_status_top.sv
// Receive lane and frame status block with APB registers and interrupt
//
// Local design decisions: the placing of the registers and register access over APB.
`timescale 1ns/100ps
`include "rls_consts.svh"
// Overview of operation
// - Separate 5-bit physical index per PCS lane
// - Index valid only while lane sync bit set
// - Sync set after lock plus marker, level
// - Demuxed flag per lane after marker found
// - Bad FCS count pulse, stomped excluded
// - Stomped FCS is inverted good FCS, counted
// - Truncate over-length packets, pulse indicator
// - Internal local fault: test pattern, misalign, BER
// - Not aligned means fault, data refused
// - Received local fault from fault monitor
// - Per-lane one-cycle BIP8 error pulse
module rls_status_top
   import rls_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   input wire logic [`RLS_NUM_LANES-1:0] block_lock,
   input wire logic [`RLS_NUM_LANES-1:0] marker_found,
   input wire logic [`RLS_NUM_LANES-1:0] marker_bad,
   input wire logic [`RLS_NUM_LANES*`RLS_IDX_W-1:0] marker_phys,
   input wire logic all_aligned,
   input wire logic hi_ber,
   input wire logic lf_seq_seen,
   input wire logic clean_column,
   input wire logic [`RLS_NUM_LANES-1:0] bip_err_in,
   input wire logic [`RLS_NUM_SEG-1:0] fcs_end,
   input wire logic [`RLS_NUM_SEG*`RLS_FCS_W-1:0] fcs_rcvd,
   input wire logic [`RLS_NUM_SEG*`RLS_FCS_W-1:0] fcs_calc,
   input wire logic beat_valid,
   input wire logic beat_sop,
   input wire logic beat_eop,
   input wire logic [`RLS_BYTES_W-1:0] beat_bytes,
   output logic pass_valid,
   output logic pass_eop,
   output logic [`RLS_NUM_LANES-1:0] lane_sync_status,
   output logic [`RLS_NUM_LANES-1:0] lane_demultiplexed_flags,
   output rls_idx_t pcs_lane_physical_index_0,
   output rls_idx_t pcs_lane_physical_index_1,
   output rls_idx_t pcs_lane_physical_index_2,
   output rls_idx_t pcs_lane_physical_index_3,
   output rls_idx_t pcs_lane_physical_index_4,
   output rls_idx_t pcs_lane_physical_index_5,
   output rls_idx_t pcs_lane_physical_index_6,
   output rls_idx_t pcs_lane_physical_index_7,
   output rls_idx_t pcs_lane_physical_index_8,
   output rls_idx_t pcs_lane_physical_index_9,
   output rls_idx_t pcs_lane_physical_index_10,
   output rls_idx_t pcs_lane_physical_index_11,
   output rls_idx_t pcs_lane_physical_index_12,
   output rls_idx_t pcs_lane_physical_index_13,
   output rls_idx_t pcs_lane_physical_index_14,
   output rls_idx_t pcs_lane_physical_index_15,
   output rls_idx_t pcs_lane_physical_index_16,
   output rls_idx_t pcs_lane_physical_index_17,
   output rls_idx_t pcs_lane_physical_index_18,
   output rls_idx_t pcs_lane_physical_index_19,
   output rls_cnt_t bad_fcs_count,
   output rls_cnt_t stomped_fcs_count,
   output logic truncated_pulse,
   output logic internal_local_fault,
   output logic received_local_fault,
   output logic [`RLS_NUM_LANES-1:0] bip8_err_pulse
);

   function automatic rls_cnt_t count_ones(input logic [`RLS_NUM_SEG-1:0] v);
      rls_cnt_t n;
      n = '0;
      for (int i = 0; i < `RLS_NUM_SEG; i++)
      begin
         n = n + {3'h0, v[i]};
      end
      return n;
   endfunction

   // Lane tracking
   logic [`RLS_NUM_LANES-1:0] synced_w;
   logic [`RLS_NUM_LANES-1:0] demuxed_w;
   logic [`RLS_NUM_LANES*`RLS_IDX_W-1:0] phys_w;

   rls_lane_tracker u_tracker (
      .clk(clk),
      .resetn(resetn),
      .block_lock(block_lock),
      .marker_found(marker_found),
      .marker_bad(marker_bad),
      .marker_phys(marker_phys),
      .synced_r(synced_w),
      .demuxed_r(demuxed_w),
      .phys_idx_r(phys_w)
   );

   assign lane_sync_status = synced_w;
   assign lane_demultiplexed_flags = demuxed_w;
   assign pcs_lane_physical_index_0 = phys_w[0*`RLS_IDX_W +: `RLS_IDX_W];
   assign pcs_lane_physical_index_1 = phys_w[1*`RLS_IDX_W +: `RLS_IDX_W];
   assign pcs_lane_physical_index_2 = phys_w[2*`RLS_IDX_W +: `RLS_IDX_W];
   assign pcs_lane_physical_index_3 = phys_w[3*`RLS_IDX_W +: `RLS_IDX_W];
   assign pcs_lane_physical_index_4 = phys_w[4*`RLS_IDX_W +: `RLS_IDX_W];
   assign pcs_lane_physical_index_5 = phys_w[5*`RLS_IDX_W +: `RLS_IDX_W];
   assign pcs_lane_physical_index_6 = phys_w[6*`RLS_IDX_W +: `RLS_IDX_W];
   assign pcs_lane_physical_index_7 = phys_w[7*`RLS_IDX_W +: `RLS_IDX_W];
   assign pcs_lane_physical_index_8 = phys_w[8*`RLS_IDX_W +: `RLS_IDX_W];
   assign pcs_lane_physical_index_9 = phys_w[9*`RLS_IDX_W +: `RLS_IDX_W];
   assign pcs_lane_physical_index_10 = phys_w[10*`RLS_IDX_W +: `RLS_IDX_W];
   assign pcs_lane_physical_index_11 = phys_w[11*`RLS_IDX_W +: `RLS_IDX_W];
   assign pcs_lane_physical_index_12 = phys_w[12*`RLS_IDX_W +: `RLS_IDX_W];
   assign pcs_lane_physical_index_13 = phys_w[13*`RLS_IDX_W +: `RLS_IDX_W];
   assign pcs_lane_physical_index_14 = phys_w[14*`RLS_IDX_W +: `RLS_IDX_W];
   assign pcs_lane_physical_index_15 = phys_w[15*`RLS_IDX_W +: `RLS_IDX_W];
   assign pcs_lane_physical_index_16 = phys_w[16*`RLS_IDX_W +: `RLS_IDX_W];
   assign pcs_lane_physical_index_17 = phys_w[17*`RLS_IDX_W +: `RLS_IDX_W];
   assign pcs_lane_physical_index_18 = phys_w[18*`RLS_IDX_W +: `RLS_IDX_W];
   assign pcs_lane_physical_index_19 = phys_w[19*`RLS_IDX_W +: `RLS_IDX_W];

   // Configuration and interrupt registers
   logic tpgen_r;
   logic [`RLS_LEN_W-1:0] maxlen_r;
   logic [`RLS_INT_W-1:0] int_stat_r;
   logic [`RLS_INT_W-1:0] int_en_r;

   // FCS classification per segment
   logic [`RLS_NUM_SEG-1:0] seg_bad;
   logic [`RLS_NUM_SEG-1:0] seg_stomp;

   always_comb
   begin
      for (int s = 0; s < `RLS_NUM_SEG; s++)
      begin
         seg_stomp[s] = fcs_end[s]
            && (fcs_rcvd[s*`RLS_FCS_W +: `RLS_FCS_W] == ~fcs_calc[s*`RLS_FCS_W +: `RLS_FCS_W]);
         seg_bad[s] = fcs_end[s] && !seg_stomp[s]
            && (fcs_rcvd[s*`RLS_FCS_W +: `RLS_FCS_W] != fcs_calc[s*`RLS_FCS_W +: `RLS_FCS_W]);
      end
   end

   // Length check and truncation
   rls_rx_e rx_st_r;
   rls_rx_e rx_st_nxt;
   logic [`RLS_LEN_W:0] len_r;
   logic [`RLS_LEN_W:0] len_base;
   logic [`RLS_LEN_W:0] len_sum;
   logic beat_ok;
   logic beat_take;
   logic too_long;
   logic trunc_now;

   // No data is taken while the lanes are not aligned
   assign beat_ok = beat_valid && all_aligned;
   // A start of frame reopens the path even inside a dropped frame
   assign beat_take = beat_ok && (beat_sop || rx_st_r != RLS_DROP);
   assign len_base = beat_sop ? '0 : len_r;
   assign len_sum = len_base + {{(`RLS_LEN_W + 1 - `RLS_BYTES_W){1'b0}}, beat_bytes};
   assign too_long = len_sum > {1'b0, maxlen_r};
   assign trunc_now = beat_take && too_long;

   always_comb
   begin
      rx_st_nxt = rx_st_r;
      case (rx_st_r)
         RLS_DROP:
         begin
            // Rest of a truncated frame is thrown away up to its end
            if (beat_ok && beat_eop)
            begin
               rx_st_nxt = RLS_IDLE;
            end
         end
         default:
         begin
            rx_st_nxt = rx_st_r;
         end
      endcase
      if (beat_take)
      begin
         rx_st_nxt = beat_eop ? RLS_IDLE : (too_long ? RLS_DROP : RLS_PKT);
      end
   end

   // Link fault monitor on received fault sequences
   logic [1:0] lf_seq_r;
   logic [6:0] lf_col_r;
   logic rlf_r;
   logic ilf_nxt;

   // Test pattern, lost alignment or high BER each force the fault
   assign ilf_nxt = tpgen_r || !all_aligned || hi_ber;

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         lf_seq_r <= '0;
         lf_col_r <= '0;
         rlf_r <= 1'b0;
      end
      else if (lf_seq_seen)
      begin
         lf_col_r <= '0;
         if (lf_seq_r == `RLS_LF_SEQ_LAST)
         begin
            rlf_r <= 1'b1;
         end
         else
         begin
            lf_seq_r <= lf_seq_r + 2'h1;
         end
      end
      else if (clean_column)
      begin
         lf_col_r <= lf_col_r + 7'h1;
         if (lf_col_r == `RLS_LF_COL_LAST)
         begin
            lf_seq_r <= '0;
            rlf_r <= 1'b0;
         end
      end
   end

   // Interrupt events; set beats a clear in the same cycle
   logic [`RLS_INT_W-1:0] int_ev;
   logic [`RLS_INT_W-1:0] int_clr;

   assign int_ev[`RLS_INT_BAD_FCS] = |seg_bad;
   assign int_ev[`RLS_INT_STOMPED] = |seg_stomp;
   assign int_ev[`RLS_INT_TRUNC] = trunc_now;
   assign int_ev[`RLS_INT_ILF] = ilf_nxt && !internal_local_fault;
   assign int_ev[`RLS_INT_RLF] = rlf_r && !received_local_fault;
   assign int_ev[`RLS_INT_BIP] = |bip_err_in;

   // APB decode
   logic setup_ph;
   logic wr_en;
   logic hit_ctrl;
   logic hit_maxlen;
   logic hit_sync;
   logic hit_demux;
   logic hit_level;
   logic hit_stat;
   logic hit_en;
   logic hit_clr;
   logic hit_any;
   logic [31:0] rd_mux;

   assign setup_ph = psel && !penable;
   assign wr_en = psel && penable && pready && pwrite;
   assign hit_ctrl = paddr == `RLS_OFF_CTRL;
   assign hit_maxlen = paddr == `RLS_OFF_MAXLEN;
   assign hit_sync = paddr == `RLS_OFF_SYNC;
   assign hit_demux = paddr == `RLS_OFF_DEMUX;
   assign hit_level = paddr == `RLS_OFF_LEVEL;
   assign hit_stat = paddr == `RLS_OFF_INT_STAT;
   assign hit_en = paddr == `RLS_OFF_INT_EN;
   assign hit_clr = paddr == `RLS_OFF_INT_CLR;
   assign hit_any = hit_ctrl || hit_maxlen || hit_sync || hit_demux || hit_level || hit_stat || hit_en || hit_clr;
   assign int_clr = (wr_en && hit_clr) ? pwdata[`RLS_INT_W-1:0] : '0;
   assign rd_mux = hit_ctrl ? {31'h0, tpgen_r}
      : hit_maxlen ? {17'h0_0000, maxlen_r}
      : hit_sync ? {12'h000, synced_w}
      : hit_demux ? {12'h000, demuxed_w}
      : hit_level ? {29'h0000_0000, all_aligned, received_local_fault, internal_local_fault}
      : hit_stat ? {26'h000_0000, int_stat_r}
      : hit_en ? {26'h000_0000, int_en_r}
      : 32'h0000_0000;

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         prdata <= '0;
         pready <= 1'b0;
         pslverr <= 1'b0;
         tpgen_r <= `RLS_CTRL_RST;
         maxlen_r <= `RLS_MAXLEN_RST;
         int_en_r <= `RLS_INT_EN_RST;
      end
      else
      begin
         pready <= setup_ph;
         pslverr <= setup_ph && !hit_any;
         prdata <= (setup_ph && !pwrite) ? rd_mux : '0;
         if (wr_en && hit_ctrl)
         begin
            tpgen_r <= pwdata[`RLS_CTRL_TPGEN_BIT];
         end
         if (wr_en && hit_maxlen)
         begin
            maxlen_r <= pwdata[`RLS_LEN_W-1:0];
         end
         if (wr_en && hit_en)
         begin
            int_en_r <= pwdata[`RLS_INT_W-1:0];
         end
      end
   end

   // Status outputs, all from flops and zero in reset
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         bad_fcs_count <= '0;
         stomped_fcs_count <= '0;
         truncated_pulse <= 1'b0;
         internal_local_fault <= 1'b0;
         received_local_fault <= 1'b0;
         bip8_err_pulse <= '0;
         rx_st_r <= RLS_IDLE;
         len_r <= '0;
         pass_valid <= 1'b0;
         pass_eop <= 1'b0;
         int_stat_r <= '0;
         irq <= 1'b0;
      end
      else
      begin
         bad_fcs_count <= count_ones(seg_bad);
         stomped_fcs_count <= count_ones(seg_stomp);
         truncated_pulse <= trunc_now;
         internal_local_fault <= ilf_nxt;
         received_local_fault <= rlf_r;
         bip8_err_pulse <= bip_err_in;
         rx_st_r <= rx_st_nxt;
         len_r <= beat_ok ? len_sum : len_r;
         pass_valid <= beat_take;
         // Truncated beat carries a forced end so downstream closes the frame
         pass_eop <= beat_take && (beat_eop || too_long);
         int_stat_r <= (int_stat_r & ~int_clr) | int_ev;
         irq <= |(((int_stat_r & ~int_clr) | int_ev) & int_en_r);
      end
   end
endmodule

// file: inc/rls_consts.svh
// Constants for the receive lane and frame status block
`ifndef RLS_CONSTS_SVH
`define RLS_CONSTS_SVH

`define RLS_NUM_LANES 20
`define RLS_IDX_W 5
`define RLS_NUM_SEG 4
`define RLS_FCS_W 32
`define RLS_LEN_W 15
`define RLS_BYTES_W 7

// APB register byte offsets
`define RLS_OFF_CTRL 12'h000
`define RLS_OFF_MAXLEN 12'h004
`define RLS_OFF_SYNC 12'h008
`define RLS_OFF_DEMUX 12'h00C
`define RLS_OFF_LEVEL 12'h010
`define RLS_OFF_INT_STAT 12'h014
`define RLS_OFF_INT_EN 12'h018
`define RLS_OFF_INT_CLR 12'h01C

// Reset values
`define RLS_MAXLEN_RST 15'h2580
`define RLS_CTRL_RST 1'h0
`define RLS_INT_EN_RST 6'h00

// Field positions
`define RLS_CTRL_TPGEN_BIT 0
`define RLS_LVL_ILF_BIT 0
`define RLS_LVL_RLF_BIT 1
`define RLS_LVL_ALIGNED_BIT 2
`define RLS_INT_W 6
`define RLS_INT_BAD_FCS 0
`define RLS_INT_STOMPED 1
`define RLS_INT_TRUNC 2
`define RLS_INT_ILF 3
`define RLS_INT_RLF 4
`define RLS_INT_BIP 5

// Link fault monitor: fault after 4 sequences, cleared after 128 clean columns
`define RLS_LF_SEQ_LAST 2'h3
`define RLS_LF_COL_LAST 7'h7F

`endif

// file: inc/rls_pkg.sv
// Types shared by the receive lane and frame status block
package rls_pkg;
   typedef logic [4:0] rls_idx_t;
   typedef logic [3:0] rls_cnt_t;
   typedef enum logic [1:0] {RLS_IDLE, RLS_PKT, RLS_DROP} rls_rx_e;
endpackage

// file: tb/rls_link_partner.sv
// Link partner model: word lock and periodic lane markers on every PCS lane
`timescale 1ns/100ps
module rls_link_partner
   import rls_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic [19:0] lock_req,
   output logic [19:0] block_lock,
   output logic [19:0] marker_found,
   output logic [99:0] marker_phys
);
   logic [2:0] tick_r;
   logic [99:0] phys_map;
   // Lane i arrives on physical lane 19-i, so no index equals its lane
   for (genvar i = 0; i < 20; i++)
   begin : g_map
      assign phys_map[5*i +: 5] = 5'(19 - i);
   end
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         tick_r <= 3'h0;
         block_lock <= 20'h0_0000;
      end
      else
      begin
         tick_r <= tick_r + 3'h1;
         block_lock <= lock_req;
      end
   end
   // Marker every eighth column; between markers the index bus carries junk
   assign marker_found = (tick_r == 3'h7) ? block_lock : 20'h0_0000;
   assign marker_phys = (tick_r == 3'h7) ? phys_map : ~phys_map;
endmodule

// file: tb/rls_status_props.sv
// Port checks for the receive lane and frame status block
`timescale 1ns/100ps
module rls_status_props
   import rls_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic [19:0] block_lock,
   input wire logic [19:0] marker_found,
   input wire logic [99:0] marker_phys,
   input wire logic [19:0] lane_sync_status,
   input wire logic [19:0] lane_demultiplexed_flags,
   input wire rls_idx_t pcs_lane_physical_index_3,
   input wire logic all_aligned,
   input wire logic hi_ber,
   input wire logic internal_local_fault,
   input wire logic pass_valid,
   input wire logic pass_eop,
   input wire logic truncated_pulse,
   input wire logic [3:0] fcs_end,
   input wire rls_cnt_t bad_fcs_count,
   input wire rls_cnt_t stomped_fcs_count,
   input wire logic lf_seq_seen,
   input wire logic received_local_fault,
   input wire logic [19:0] bip_err_in,
   input wire logic [19:0] bip8_err_pulse
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   property p_bip;
      bip_err_in != 20'h0_0000 |=> bip8_err_pulse == $past(bip_err_in);
   endproperty
   a_bip: assert property (p_bip) else $error("bip pulse mismatch");
   property p_sync;
      block_lock[3] && marker_found[3] |=> lane_sync_status[3] && pcs_lane_physical_index_3 == $past(marker_phys[19:15]);
   endproperty
   a_sync: assert property (p_sync) else $error("lane sync or index wrong");
   property p_unsync;
      !block_lock[3] |=> !lane_sync_status[3];
   endproperty
   a_unsync: assert property (p_unsync) else $error("sync kept without lock");
   property p_demux;
      (lane_demultiplexed_flags & ~lane_sync_status) == 20'h0_0000;
   endproperty
   a_demux: assert property (p_demux) else $error("demuxed lane not synced");
   property p_ilf;
      !all_aligned || hi_ber |=> internal_local_fault;
   endproperty
   a_ilf: assert property (p_ilf) else $error("internal fault missing");
   property p_refuse;
      !all_aligned |=> !pass_valid;
   endproperty
   a_refuse: assert property (p_refuse) else $error("data passed while misaligned");
   property p_fcs;
      1'b1 |=> 5'(bad_fcs_count) + 5'(stomped_fcs_count) <= $countones($past(fcs_end));
   endproperty
   a_fcs: assert property (p_fcs) else $error("fcs counts exceed ended packets");
   property p_trunc;
      truncated_pulse |-> pass_valid && pass_eop;
   endproperty
   a_trunc: assert property (p_trunc) else $error("truncation without forced end");
   property p_rlf;
      $rose(received_local_fault) |-> $past(lf_seq_seen, 2);
   endproperty
   a_rlf: assert property (p_rlf) else $error("received fault rose without sequence");
   c_trunc: cover property (truncated_pulse);
   c_stomp: cover property (stomped_fcs_count != 4'h0);
   c_rlf: cover property ($rose(received_local_fault));
endmodule
bind rls_status_top rls_status_props chk_u (.clk(clk), .resetn(resetn), .block_lock(block_lock),
   .marker_found(marker_found), .marker_phys(marker_phys), .lane_sync_status(lane_sync_status),
   .lane_demultiplexed_flags(lane_demultiplexed_flags), .pcs_lane_physical_index_3(pcs_lane_physical_index_3),
   .all_aligned(all_aligned), .hi_ber(hi_ber), .internal_local_fault(internal_local_fault),
   .pass_valid(pass_valid), .pass_eop(pass_eop), .truncated_pulse(truncated_pulse), .fcs_end(fcs_end),
   .bad_fcs_count(bad_fcs_count), .stomped_fcs_count(stomped_fcs_count), .lf_seq_seen(lf_seq_seen),
   .received_local_fault(received_local_fault), .bip_err_in(bip_err_in), .bip8_err_pulse(bip8_err_pulse));

// file: tb/rls_status_top_tb.sv
// Self-checking bench for the receive lane and frame status block
`timescale 1ns/100ps
`include "rls_consts.svh"
module rls_status_top_tb
   import rls_pkg::*;
;
   logic clk, resetn, psel, penable, pwrite, pready, pslverr, irq, err, all_aligned, hi_ber, lf_seq_seen;
   logic clean_column, beat_valid, beat_sop, beat_eop, pass_valid, pass_eop, truncated_pulse, ilf, rlf;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [6:0] beat_bytes;
   logic [19:0] lock_req, block_lock, marker_found, marker_bad, bip_err_in, sync_st, demux_st, bip8;
   logic [99:0] marker_phys;
   logic [3:0] fcs_end;
   logic [127:0] fcs_rcvd, fcs_calc;
   rls_idx_t pi [20];
   rls_cnt_t bad_cnt, stomp_cnt;
   int n_errors = 0;
   int cmp_count = 0;
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   rls_link_partner lp_u (.clk(clk), .resetn(resetn), .lock_req(lock_req), .block_lock(block_lock),
      .marker_found(marker_found), .marker_phys(marker_phys));
   rls_status_top dut_u (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
      .block_lock(block_lock), .marker_found(marker_found), .marker_bad(marker_bad), .marker_phys(marker_phys),
      .all_aligned(all_aligned), .hi_ber(hi_ber), .lf_seq_seen(lf_seq_seen), .clean_column(clean_column),
      .bip_err_in(bip_err_in), .fcs_end(fcs_end), .fcs_rcvd(fcs_rcvd), .fcs_calc(fcs_calc),
      .beat_valid(beat_valid), .beat_sop(beat_sop), .beat_eop(beat_eop), .beat_bytes(beat_bytes),
      .pass_valid(pass_valid), .pass_eop(pass_eop), .lane_sync_status(sync_st), .lane_demultiplexed_flags(demux_st),
      .pcs_lane_physical_index_0(pi[0]), .pcs_lane_physical_index_1(pi[1]), .pcs_lane_physical_index_2(pi[2]),
      .pcs_lane_physical_index_3(pi[3]), .pcs_lane_physical_index_4(pi[4]), .pcs_lane_physical_index_5(pi[5]),
      .pcs_lane_physical_index_6(pi[6]), .pcs_lane_physical_index_7(pi[7]), .pcs_lane_physical_index_8(pi[8]),
      .pcs_lane_physical_index_9(pi[9]), .pcs_lane_physical_index_10(pi[10]),
      .pcs_lane_physical_index_11(pi[11]), .pcs_lane_physical_index_12(pi[12]),
      .pcs_lane_physical_index_13(pi[13]), .pcs_lane_physical_index_14(pi[14]),
      .pcs_lane_physical_index_15(pi[15]), .pcs_lane_physical_index_16(pi[16]),
      .pcs_lane_physical_index_17(pi[17]), .pcs_lane_physical_index_18(pi[18]),
      .pcs_lane_physical_index_19(pi[19]), .bad_fcs_count(bad_cnt), .stomped_fcs_count(stomp_cnt),
      .truncated_pulse(truncated_pulse), .internal_local_fault(ilf), .received_local_fault(rlf),
      .bip8_err_pulse(bip8));
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         n_errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic give_verdict;
      if (n_errors == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // Entered just after a rising edge; ends one idle edge later so callers may chain
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      if (n >= 50)
         n_errors++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   initial
   begin
      repeat (5000) @(posedge clk);
      n_errors++;
      give_verdict;
   end
   initial
   begin
      resetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata, all_aligned, hi_ber, lf_seq_seen, clean_column, beat_valid, beat_sop,
         beat_eop, beat_bytes, lock_req, marker_bad, bip_err_in, fcs_end, fcs_rcvd, fcs_calc} = '0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      @(negedge clk);
      chk("reset outputs", 32'h0, {bad_cnt, stomp_cnt, truncated_pulse, bip8, irq, pready});
      repeat (3) @(negedge clk);
      chk("ilf misaligned", 32'h1, ilf);
      @(posedge clk);
      apb(1'b0, `RLS_OFF_MAXLEN, 32'h0);
      chk("maxlen reset", 32'h0000_2580, rd);
      apb(1'b0, 12'h020, 32'h0);
      chk("unmapped err", 32'h1, err);
      apb(1'b1, `RLS_OFF_MAXLEN, 32'h0000_0064);
      lock_req <= 20'hF_FFFF;
      repeat (12) @(negedge clk);
      chk("sync all", 32'h000F_FFFF, sync_st);
      chk("demux all", 32'h000F_FFFF, demux_st);
      for (int i = 0; i < 20; i++)
         chk("phys index", 32'(19 - i), pi[i]);
      @(posedge clk);
      lock_req[3] <= 1'b0;
      repeat (3) @(negedge clk);
      chk("sync lock lost", 32'h000F_FFF7, sync_st);
      chk("demux lock lost", 32'h000F_FFF7, demux_st);
      @(posedge clk);
      marker_bad <= 20'h0_0020;
      @(posedge clk);
      marker_bad <= 20'h0_0000;
      @(negedge clk);
      chk("demux bad marker", 32'h000F_FFD7, demux_st);
      @(posedge clk);
      apb(1'b0, `RLS_OFF_SYNC, 32'h0);
      chk("sync reg", 32'h000F_FFF7, rd);
      fcs_calc <= {4{32'h1234_5678}};
      fcs_rcvd <= {32'h1234_5678, 32'hEDCB_A987, 32'hEDCB_A987, 32'h1234_5679};
      fcs_end <= 4'hF;
      @(posedge clk);
      fcs_rcvd <= {4{32'h1234_5670}};
      @(negedge clk);
      chk("bad mixed", 32'h1, bad_cnt);
      chk("stomped mixed", 32'h2, stomp_cnt);
      @(posedge clk);
      fcs_end <= 4'h0;
      bip_err_in <= 20'h8_0001;
      @(negedge clk);
      chk("bad back to back", 32'h4, bad_cnt);
      chk("irq masked", 32'h0, irq);
      @(posedge clk);
      bip_err_in <= 20'h0_0002;
      @(negedge clk);
      chk("bip first", 32'h0008_0001, bip8);
      @(posedge clk);
      bip_err_in <= 20'h0_0000;
      all_aligned <= 1'b1;
      @(negedge clk);
      chk("bip second", 32'h0000_0002, bip8);
      @(negedge clk);
      chk("ilf aligned", 32'h0, ilf);
      @(posedge clk);
      apb(1'b1, `RLS_OFF_CTRL, 32'h0000_0001);
      @(negedge clk);
      chk("ilf test pattern", 32'h1, ilf);
      @(posedge clk);
      apb(1'b1, `RLS_OFF_CTRL, 32'h0);
      hi_ber <= 1'b1;
      repeat (2) @(negedge clk);
      chk("ilf high ber", 32'h1, ilf);
      @(posedge clk);
      hi_ber <= 1'b0;
      apb(1'b1, `RLS_OFF_INT_CLR, 32'h0000_003F);
      apb(1'b1, `RLS_OFF_INT_EN, 32'h0000_0004);
      {beat_valid, beat_sop, beat_bytes} <= {2'h3, 7'h40};
      @(posedge clk);
      beat_sop <= 1'b0;
      @(posedge clk);
      {beat_eop, beat_bytes} <= {1'b1, 7'h0A};
      @(negedge clk);
      chk("trunc forced end", 32'h3, {truncated_pulse, pass_eop});
      @(posedge clk);
      {beat_valid, beat_eop} <= 2'h0;
      @(negedge clk);
      chk("beat after trunc", 32'h0, pass_valid);
      repeat (2) @(negedge clk);
      chk("irq trunc", 32'h1, irq);
      @(posedge clk);
      apb(1'b0, `RLS_OFF_INT_STAT, 32'h0);
      chk("stat trunc", 32'h4, rd & 32'h0000_0004);
      apb(1'b1, `RLS_OFF_INT_CLR, 32'h0000_0004);
      repeat (2) @(negedge clk);
      chk("irq cleared", 32'h0, irq);
      @(posedge clk);
      for (int k = 0; k < 4; k++)
      begin
         lf_seq_seen <= 1'b1;
         @(posedge clk);
         lf_seq_seen <= 1'b0;
         @(posedge clk);
      end
      repeat (3) @(negedge clk);
      chk("rlf set", 32'h1, rlf);
      @(posedge clk);
      apb(1'b0, `RLS_OFF_LEVEL, 32'h0);
      chk("level reg", 32'h6, rd);
      clean_column <= 1'b1;
      // One short of the clearing count must leave the fault standing
      repeat (127) @(posedge clk);
      @(negedge clk);
      chk("rlf held", 32'h1, rlf);
      @(posedge clk);
      clean_column <= 1'b0;
      repeat (3) @(negedge clk);
      chk("rlf cleared", 32'h0, rlf);
      give_verdict;
   end
endmodule
